// ==== pohacc_pkg.sv ====
// package for the palette overlay host access block
package pohacc_pkg;

    localparam int POHACC_DATA_W = 8;
    localparam int POHACC_COLOR_W = 24;
    localparam int POHACC_PAL_DEPTH = 256;
    localparam int POHACC_OVL_DEPTH = 4;
    localparam int POHACC_CTL_DEPTH = 4;
    localparam logic [7:0] POHACC_PTR_RESET = 8'h00;
    localparam logic [7:0] POHACC_CTL_BASE = 8'h04;
    localparam logic [7:0] POHACC_CTL_LAST = 8'h07;
    localparam logic [7:0] POHACC_OVL_LAST = 8'h03;
    localparam logic [1:0] POHACC_PH_RED = 2'h0;
    localparam logic [1:0] POHACC_PH_GREEN = 2'h1;
    localparam logic [1:0] POHACC_PH_BLUE = 2'h2;
    // select codes {target_select_hi, target_select_lo}
    localparam logic [1:0] POHACC_SEL_PTR = 2'h0;
    localparam logic [1:0] POHACC_SEL_PAL = 2'h1;
    localparam logic [1:0] POHACC_SEL_CTL = 2'h2;
    localparam logic [1:0] POHACC_SEL_OVL = 2'h3;

    // host bus pins sampled at the clock
    typedef struct packed {
        logic chip_enable_n;
        logic read_not_write;
        logic target_select_hi;
        logic target_select_lo;
        logic [7:0] host_data_bus;
    } pohacc_host_in_type;

    // display refresh read request
    typedef struct packed {
        logic [7:0] pixel_index;
        logic [1:0] overlay_index;
    } pohacc_disp_in_type;

    // display refresh read data
    typedef struct packed {
        logic [23:0] palette_color;
        logic [23:0] overlay_color;
    } pohacc_disp_out_type;
endpackage

// ==== pohacc_top.sv ====
// host access logic for a palette and overlay colour store
`timescale 1ns/100ps
module pohacc_top #(
    parameter int PAL_DEPTH = pohacc_pkg::POHACC_PAL_DEPTH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // host bus
    input wire pohacc_pkg::pohacc_host_in_type host_i,
    output logic [7:0] host_data_o,
    output logic host_data_oe_o,
    // display refresh port
    input wire pohacc_pkg::pohacc_disp_in_type disp_i,
    output pohacc_pkg::pohacc_disp_out_type disp_o,
    // control register contents for the pixel path
    output logic [31:0] control_regs_o
);
    import pohacc_pkg::*;

    // the pointer is 8 bits, so the palette must fill it for the wrap to hold
    if (PAL_DEPTH != POHACC_PAL_DEPTH) begin : g_bad_depth
        $error("pohacc_top: PAL_DEPTH must be 256");
    end

    // all control state in one struct
    typedef struct packed {
        logic [7:0] palette_index_pointer;  // host index pointer
        logic [1:0] component_phase_counter; // red/green/blue phase
        logic [7:0] red_hold;               // held red byte
        logic [7:0] green_hold;             // held green byte
        logic ce_n_prev;                    // strobe history for edge find
        logic [7:0] rdata;                  // read data driven to bus
        logic oe;                           // bus drive enable
        logic [31:0] ctl;                   // four control registers
        logic [23:0] disp_pal;              // display palette read
        logic [23:0] disp_ovl;              // display overlay read
    } pohacc_state_type;

    pohacc_state_type state_q;
    pohacc_state_type state_d;

    // storage arrays, written only from the host side
    logic [23:0] palette_mem [PAL_DEPTH];
    logic [23:0] overlay_mem [POHACC_OVL_DEPTH];

    // decoded access controls
    logic strobe_start;   // falling strobe edge: one action per cycle
    logic [1:0] sel;
    logic ptr_ok;         // pointer valid for the selected target
    logic pal_wr;
    logic ovl_wr;
    logic [23:0] wr_word;
    logic [23:0] rd_word;
    logic [7:0] ctl_off;

    // strobe edge and target decode
    always_comb begin
        strobe_start = state_q.ce_n_prev && !host_i.chip_enable_n;
        sel = {host_i.target_select_hi, host_i.target_select_lo};
        ctl_off = state_q.palette_index_pointer - POHACC_CTL_BASE;
        // validity of the pointer per target
        if (sel == POHACC_SEL_OVL) begin
            ptr_ok = state_q.palette_index_pointer <= POHACC_OVL_LAST;
        end else if (sel == POHACC_SEL_CTL) begin
            ptr_ok = (state_q.palette_index_pointer >= POHACC_CTL_BASE) &&
                     (state_q.palette_index_pointer <= POHACC_CTL_LAST);
        end else begin
            ptr_ok = 1'b1;
        end
        wr_word = {state_q.red_hold, state_q.green_hold, host_i.host_data_bus};
        // blue writes reach storage only with a valid pointer
        pal_wr = strobe_start && !host_i.read_not_write && (sel == POHACC_SEL_PAL) &&
                 (state_q.component_phase_counter == POHACC_PH_BLUE);
        ovl_wr = strobe_start && !host_i.read_not_write && (sel == POHACC_SEL_OVL) &&
                 ptr_ok && (state_q.component_phase_counter == POHACC_PH_BLUE);
        // reads take the word as it stands at the strobe; the display keeps
        // its own read port, so refresh never waits for host traffic
        if (sel == POHACC_SEL_OVL) begin
            rd_word = overlay_mem[state_q.palette_index_pointer[1:0]];
        end else begin
            rd_word = palette_mem[state_q.palette_index_pointer];
        end
    end

    // next state
    always_comb begin
        state_d = state_q;
        // remember the strobe level; only a fall starts a data cycle
        state_d.ce_n_prev = host_i.chip_enable_n;
        // release the bus when the strobe ends
        if (host_i.chip_enable_n) begin
            state_d.oe = 1'b0;
        end
        // display port reads run every clock, apart from host traffic
        state_d.disp_pal = palette_mem[disp_i.pixel_index];
        state_d.disp_ovl = overlay_mem[disp_i.overlay_index];
        if (strobe_start) begin
            state_d.oe = host_i.read_not_write;
            if (sel == POHACC_SEL_PTR) begin
                // pointer access resets the phase
                state_d.component_phase_counter = POHACC_PH_RED;
                state_d.rdata = state_q.palette_index_pointer;
                if (!host_i.read_not_write) begin
                    state_d.palette_index_pointer = host_i.host_data_bus;
                end
            end else if (sel == POHACC_SEL_CTL) begin
                // read-modify-write friendly: pointer stays put
                state_d.rdata = state_q.ctl[ctl_off[1:0]*8 +: 8];
                if (!host_i.read_not_write && ptr_ok) begin
                    state_d.ctl[ctl_off[1:0]*8 +: 8] = host_i.host_data_bus;
                end
            end else begin
                // colour access, palette or overlay
                case (state_q.component_phase_counter)
                    POHACC_PH_RED: begin
                        state_d.rdata = rd_word[23:16];
                        if (!host_i.read_not_write && ptr_ok) begin
                            state_d.red_hold = host_i.host_data_bus;
                        end
                        state_d.component_phase_counter = POHACC_PH_GREEN;
                    end
                    POHACC_PH_GREEN: begin
                        state_d.rdata = rd_word[15:8];
                        if (!host_i.read_not_write && ptr_ok) begin
                            state_d.green_hold = host_i.host_data_bus;
                        end
                        state_d.component_phase_counter = POHACC_PH_BLUE;
                    end
                    default: begin
                        state_d.rdata = rd_word[7:0];
                        state_d.component_phase_counter = POHACC_PH_RED;
                        // 8-bit add wraps FF to 00; overlay 03 simply goes to 04
                        state_d.palette_index_pointer =
                            state_q.palette_index_pointer + 8'h01;
                    end
                endcase
            end
        end
    end

    // state register
    // reset clears the phase, so the first colour byte afterwards is red;
    // the strobe history resets low, so a strobe already low is ignored
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // storage writes; no reset, contents undefined at power-up
    // a blue write on the entry the display is reading may disturb one
    // pixel: the display sees either the old or the new word
    always_ff @(posedge clk_i) begin
        if (pal_wr) begin
            palette_mem[state_q.palette_index_pointer] <= wr_word;
        end
        if (ovl_wr) begin
            overlay_mem[state_q.palette_index_pointer[1:0]] <= wr_word;
        end
    end

    // outputs straight from flops
    // control bytes leave as one word, byte k for index 04+k
    assign host_data_o = state_q.rdata;
    assign host_data_oe_o = state_q.oe;
    assign disp_o.palette_color = state_q.disp_pal;
    assign disp_o.overlay_color = state_q.disp_ovl;
    assign control_regs_o = state_q.ctl;

    // assertions
    sequence s_blue_strobe;
        strobe_start && (sel != POHACC_SEL_PTR) && (sel != POHACC_SEL_CTL) &&
        (state_q.component_phase_counter == POHACC_PH_BLUE);
    endsequence

    AST_PTR_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
        strobe_start && sel == POHACC_SEL_PTR && !host_i.read_not_write |=>
        state_q.palette_index_pointer == $past(host_i.host_data_bus))
        else $error("pointer not loaded");
    AST_PHASE_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
        strobe_start && sel == POHACC_SEL_PTR |=> state_q.component_phase_counter == 2'h0)
        else $error("phase not cleared");
    AST_PHASE_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q.component_phase_counter != 2'h3)
        else $error("phase out of range");
    AST_PHASE_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
        strobe_start && (sel[0] == 1'b1) && state_q.component_phase_counter == 2'h0 |=>
        state_q.component_phase_counter == 2'h1)
        else $error("phase did not advance");
    AST_BLUE_INC: assert property (@(posedge clk_i) disable iff (rst_i)
        s_blue_strobe |=>
        state_q.palette_index_pointer == $past(state_q.palette_index_pointer) + 8'h01)
        else $error("pointer not incremented");
    AST_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
        s_blue_strobe ##0 (state_q.palette_index_pointer == 8'hFF) |=>
        state_q.palette_index_pointer == 8'h00)
        else $error("pointer did not wrap");
    AST_CTL_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        strobe_start && sel == POHACC_SEL_CTL |=> $stable(state_q.palette_index_pointer))
        else $error("control access moved pointer");
    AST_RG_NOWRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q.component_phase_counter != POHACC_PH_BLUE |-> !pal_wr && !ovl_wr)
        else $error("storage written off blue");
    AST_OVL_BAD: assert property (@(posedge clk_i) disable iff (rst_i)
        sel == POHACC_SEL_OVL && state_q.palette_index_pointer > 8'h03 |-> !ovl_wr)
        else $error("overlay written with bad pointer");
    AST_READ_OE: assert property (@(posedge clk_i) disable iff (rst_i)
        strobe_start && host_i.read_not_write |=> host_data_oe_o ##1 1'b1)
        else $error("read did not drive bus");

    // named steps shared by the properties below
    // a strobe that moves a colour byte, palette or overlay
    sequence s_color_strobe;
        strobe_start && sel[0];
    endsequence
    // a strobe aimed at the index pointer itself
    sequence s_ptr_strobe;
        strobe_start && (sel == POHACC_SEL_PTR);
    endsequence
    // a colour write strobe whose pointer the target accepts
    sequence s_color_write;
        strobe_start && sel[0] && !host_i.read_not_write && ptr_ok;
    endsequence
    // a control register strobe whose pointer lies outside 04-07
    sequence s_ctl_refused;
        strobe_start && (sel == POHACC_SEL_CTL) && !ptr_ok;
    endsequence

    // a pointer read hands back the pointer as it stood at the strobe
    AST_PTR_READ: assert property (@(posedge clk_i) disable iff (rst_i)
        s_ptr_strobe ##0 host_i.read_not_write |=>
        host_data_o == $past(state_q.palette_index_pointer))
        else $error("pointer read returned wrong value");
    // red and green bytes land in their holding registers
    AST_RED_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        s_color_write ##0 (state_q.component_phase_counter == POHACC_PH_RED) |=>
        state_q.red_hold == $past(host_i.host_data_bus))
        else $error("red byte not held");
    AST_GREEN_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        s_color_write ##0 (state_q.component_phase_counter == POHACC_PH_GREEN) |=>
        state_q.green_hold == $past(host_i.host_data_bus))
        else $error("green byte not held");
    // red and green cycles never move the pointer
    AST_RG_PTR_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        s_color_strobe ##0 (state_q.component_phase_counter != POHACC_PH_BLUE) |=>
        $stable(state_q.palette_index_pointer))
        else $error("pointer moved off blue");
    // green is followed by blue, and blue by red
    AST_PHASE_TO_BLUE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_color_strobe ##0 (state_q.component_phase_counter == POHACC_PH_GREEN) |=>
        state_q.component_phase_counter == POHACC_PH_BLUE)
        else $error("phase did not reach blue");
    AST_PHASE_TO_RED: assert property (@(posedge clk_i) disable iff (rst_i)
        s_color_strobe ##0 (state_q.component_phase_counter == POHACC_PH_BLUE) |=>
        state_q.component_phase_counter == POHACC_PH_RED)
        else $error("phase did not return to red");
    // the last overlay hands on to the first control register, not to 00
    AST_OVL_TO_CTL: assert property (@(posedge clk_i) disable iff (rst_i)
        s_blue_strobe ##0 (sel == POHACC_SEL_OVL) ##0
        (state_q.palette_index_pointer == POHACC_OVL_LAST) |=>
        state_q.palette_index_pointer == POHACC_CTL_BASE)
        else $error("overlay 03 did not advance to 04");
    // a refused control write leaves every control byte alone
    AST_CTL_REFUSED: assert property (@(posedge clk_i) disable iff (rst_i)
        s_ctl_refused |=> $stable(state_q.ctl))
        else $error("refused control write changed a register");
    // each control byte takes host data only when the pointer names it
    for (genvar b = 0; b < POHACC_CTL_DEPTH; b++) begin : g_ctl_chk
        AST_CTL_BYTE: assert property (@(posedge clk_i) disable iff (rst_i)
            strobe_start && (sel == POHACC_SEL_CTL) && !host_i.read_not_write &&
            (state_q.palette_index_pointer == POHACC_CTL_BASE + 8'(b)) |=>
            control_regs_o[b*8 +: 8] == $past(host_i.host_data_bus))
            else $error("control byte not written");
        AST_CTL_RDBACK: assert property (@(posedge clk_i) disable iff (rst_i)
            strobe_start && (sel == POHACC_SEL_CTL) && host_i.read_not_write &&
            (state_q.palette_index_pointer == POHACC_CTL_BASE + 8'(b)) |=>
            host_data_o == $past(control_regs_o[b*8 +: 8]))
            else $error("control byte read back wrong");
    end
    // the bus is let go the cycle after the strobe is seen high
    AST_OE_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
        host_i.chip_enable_n |=> !host_data_oe_o)
        else $error("bus still driven after strobe");
    // a write never drives the bus, so the host can drive it unopposed
    AST_WRITE_NO_OE: assert property (@(posedge clk_i) disable iff (rst_i)
        strobe_start && !host_i.read_not_write |=> !host_data_oe_o)
        else $error("write drove the bus");
    // read data stands until the next strobe, however long the host waits
    AST_RD_STAND: assert property (@(posedge clk_i) disable iff (rst_i)
        !strobe_start |=> $stable(host_data_o))
        else $error("read data changed without strobe");
    // without a new strobe the pointer and the phase stand still
    AST_IDLE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        !strobe_start |=>
        $stable(state_q.palette_index_pointer) && $stable(state_q.component_phase_counter))
        else $error("state moved without strobe");
    // a long low strobe still counts as one cycle
    AST_ONE_STROBE: assert property (@(posedge clk_i) disable iff (rst_i)
        strobe_start |=> !strobe_start)
        else $error("one strobe taken twice");
endmodule

// ==== pohacc_host.sv ====
// host bus partner model that strobes single byte cycles into the block
`timescale 1ns/100ps
module pohacc_host (
    // clock
    input wire logic clk_i,
    // host bus
    output pohacc_pkg::pohacc_host_in_type host_o,
    input wire logic [7:0] host_data_i,
    input wire logic host_data_oe_i
);
    import pohacc_pkg::*;
    // strobe idle high from time zero so the first fall is seen as new
    initial host_o = {1'b1, 1'b1, 2'h0, 8'h00};
    // one strobe: set after an edge, held two clocks low, then one clock high
    task automatic xfer(input logic rnw, input logic [1:0] sel, input logic [7:0] wd,
                        output logic [7:0] rd, output logic oe);
        @(posedge clk_i);
        host_o <= {1'b0, rnw, sel, wd};
        repeat (2) @(posedge clk_i);
        rd = host_data_i;
        oe = host_data_oe_i;
        // released lines change so a stale value can never pass for held data
        host_o <= {1'b1, ~rnw, ~sel, ~wd};
        @(posedge clk_i);
    endtask
endmodule

// ==== pohacc_bench.sv ====
// self-checking bench comparing the block with an integer palette model
`timescale 1ns/100ps
module pohacc_bench;
    import pohacc_pkg::*;
    logic clk_i = 1'b0; // 50 ns clock
    logic rst_i = 1'b1; // held for 16 clocks
    pohacc_host_in_type host; // driven by the host model
    pohacc_disp_in_type disp = '0; // display read addresses
    pohacc_disp_out_type disp_o;
    logic [7:0] hdata;
    logic hoe; // bus drive enable from the block
    logic [31:0] ctl_o;
    int mismatches = 0;
    int tests_run = 0;
    int pal [256]; // only written entries are ever compared
    int ovl [4];
    int ctl [4] = '{0, 0, 0, 0};
    int hold [3];
    int ptr = 0;
    int ph = 0;
    pohacc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .host_i(host), .host_data_o(hdata),
        .host_data_oe_o(hoe), .disp_i(disp), .disp_o(disp_o), .control_regs_o(ctl_o));
    pohacc_host i_host (.clk_i(clk_i), .host_o(host), .host_data_i(hdata),
        .host_data_oe_i(hoe));
    // clock generator
    always #25 clk_i = ~clk_i;
    // compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one host cycle, mirrored into the model; reads compared where defined
    task automatic acc(input logic rnw, input logic [1:0] sel, input logic [7:0] wd);
        logic [7:0] rd;
        logic oe;
        int exp;
        int word;
        logic ok;
        i_host.xfer(rnw, sel, wd, rd, oe);
        chk("bus drive", {31'h0, oe}, {31'h0, rnw});
        ok = 1'b1;
        if (sel == POHACC_SEL_PTR) begin
            exp = ptr;
            if (!rnw) ptr = wd;
            ph = 0;
        end else if (sel == POHACC_SEL_CTL) begin
            ok = ptr inside {[4:7]};
            exp = ctl[ptr & 3];
            if (!rnw && ok) ctl[ptr & 3] = wd;
        end else begin
            ok = sel == POHACC_SEL_PAL || ptr < 4;
            exp = (sel == POHACC_SEL_PAL ? pal[ptr] : ovl[ptr & 3]) >> (8 * (2 - ph));
            // only accepted writes fill the holds; reads leave them alone
            if (!rnw && ok) hold[ph] = wd;
            word = (hold[0] << 16) | (hold[1] << 8) | wd;
            if (ph == 2 && !rnw && ok && sel == POHACC_SEL_PAL) pal[ptr] = word;
            if (ph == 2 && !rnw && ok && sel == POHACC_SEL_OVL) ovl[ptr & 3] = word;
            if (ph == 2) ptr = (ptr + 1) & 255;
            ph = (ph + 1) % 3;
        end
        if (rnw && ok) chk("read byte", {24'h0, rd}, exp & 255);
    endtask
    // display port reads the stored words one cycle after the address
    task automatic disp_chk(input int pi, input int oi);
        disp <= '{pixel_index: pi[7:0], overlay_index: oi[1:0]};
        repeat (2) @(posedge clk_i);
        chk("palette colour", disp_o.palette_color, pal[pi] & 32'hFFFFFF);
        chk("overlay colour", disp_o.overlay_color, ovl[oi] & 32'hFFFFFF);
    endtask
    // verdict
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // watchdog, far beyond the few hundred clocks the tests need
    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        end_sim();
    end
    // main sequence
    initial begin
        void'($urandom(32));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("control after reset", ctl_o, 32'h0);
        acc(1'b1, POHACC_SEL_PTR, 8'h00);
        $display("test reset done");
        // all four overlays, pointer must land on 04
        acc(1'b0, POHACC_SEL_PTR, 8'h00);
        repeat (12) acc(1'b0, POHACC_SEL_OVL, 8'($urandom));
        acc(1'b1, POHACC_SEL_PTR, 8'h00);
        acc(1'b0, POHACC_SEL_PTR, 8'h00);
        repeat (12) acc(1'b1, POHACC_SEL_OVL, 8'h00);
        // a triple at pointer 04 is refused, overlays checked later
        repeat (3) acc(1'b0, POHACC_SEL_OVL, 8'($urandom));
        acc(1'b1, POHACC_SEL_PTR, 8'h00);
        $display("test overlay done");
        // palette across the top: stray red first, then reload clears phase
        acc(1'b0, POHACC_SEL_PTR, 8'hFE);
        acc(1'b0, POHACC_SEL_PAL, 8'($urandom));
        acc(1'b0, POHACC_SEL_PTR, 8'hFE);
        repeat (6) acc(1'b0, POHACC_SEL_PAL, 8'($urandom));
        acc(1'b1, POHACC_SEL_PTR, 8'h00);
        // a red read, then a pointer read must restart at red
        acc(1'b0, POHACC_SEL_PTR, 8'hFE);
        acc(1'b1, POHACC_SEL_PAL, 8'h00);
        acc(1'b1, POHACC_SEL_PTR, 8'h00);
        repeat (6) acc(1'b1, POHACC_SEL_PAL, 8'h00);
        disp_chk(255, 3);
        disp_chk(254, 0);
        // partial triple over a written entry: no store, pointer stays
        acc(1'b0, POHACC_SEL_PTR, 8'hFE);
        repeat (2) acc(1'b0, POHACC_SEL_PAL, 8'($urandom));
        acc(1'b1, POHACC_SEL_PTR, 8'h00);
        disp_chk(254, 1);
        $display("test palette done");
        // reset mid-run with the pointer at FE and the phase already red: writes restart at entry 00
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        ptr = 0;
        ph = 0;
        ctl = '{0, 0, 0, 0};
        @(posedge clk_i);
        chk("control after reset", ctl_o, 32'h0);
        repeat (3) acc(1'b0, POHACC_SEL_PAL, 8'($urandom));
        disp_chk(0, 2);
        acc(1'b1, POHACC_SEL_PTR, 8'h00);
        $display("test mid-run reset done");
        // control registers: no pointer advance, then an invalid pointer
        for (int k = 4; k < 9; k++) begin
            acc(1'b0, POHACC_SEL_PTR, 8'(k));
            acc(1'b0, POHACC_SEL_CTL, 8'($urandom));
            acc(1'b1, POHACC_SEL_PTR, 8'h00);
            acc(1'b0, POHACC_SEL_PTR, 8'(k));
            acc(1'b1, POHACC_SEL_CTL, 8'h00);
            chk("control bytes", ctl_o,
                {ctl[3][7:0], ctl[2][7:0], ctl[1][7:0], ctl[0][7:0]});
        end
        $display("test control done");
        end_sim();
    end
endmodule
